// ---- logic/urd_pkg.sv ----
/*
  Constants, field positions and carrier types for one channel of the
  quad UART register access decoder.
  Assumes an 8-bit host bus with four active-low channel selects,
  all host signals already synchronous to sys_clk.

  // Notes on behaviour
  // - Readiness status at offset 7 is read-only; host writes never change it.
  // - Readiness status reads need any select low, modem bit 2 set, loop-back off.
  // - Line control 0xBF maps offset 6 to pause char one, 4 to resume one.
  // - Line control 0xBF maps offset 7 to pause char two, 5 to resume two.
  // - Line control 0xBF maps offset 2 to the enhanced feature register.
  // - Enhanced enable plus modem bit 6 map offset 6 to flow thresholds.
  // - Same conditions map offset 7 to the FIFO trigger levels.
  // - Modem control bit 7 clear gives prescaler divide-by-one.
  // - Modem control bit 7 set gives prescaler divide-by-four.
  // - Without enhanced enable, writes to enable[7:4], fifo[5:4], modem[7:5] ignored.
  // - Threshold writes only with enhanced enable and modem bit 6; halt above resume.
*/
package urd_pkg;

  localparam int URD_CHANNELS = 4;

  typedef logic [2:0] urd_addr_t;
  typedef logic [7:0] urd_byte_t;

  // Host offsets
  localparam urd_addr_t OFS_0 = 3'h0;
  localparam urd_addr_t OFS_1 = 3'h1;
  localparam urd_addr_t OFS_2 = 3'h2;
  localparam urd_addr_t OFS_3 = 3'h3;
  localparam urd_addr_t OFS_4 = 3'h4;
  localparam urd_addr_t OFS_5 = 3'h5;
  localparam urd_addr_t OFS_6 = 3'h6;
  localparam urd_addr_t OFS_7 = 3'h7;

  // Bank keys and field positions
  localparam urd_byte_t LINE_ENH_BANK = 8'hBF;
  localparam int LINE_DIV_BIT = 7;
  localparam int FEAT_ENH_BIT = 4;
  localparam int MODEM_RDY_EN_BIT = 2;
  localparam int MODEM_LOOP_BIT = 4;
  localparam int MODEM_EXT_BIT = 6;
  localparam int MODEM_PRESCALE_BIT = 7;

  // Bits writable only with enhanced enable
  localparam urd_byte_t INT_EN_ENH_MASK = 8'hF0;
  localparam urd_byte_t FIFO_CTL_ENH_MASK = 8'h30;
  localparam urd_byte_t MODEM_ENH_MASK = 8'hE0;

  localparam urd_byte_t REG_RESET = 8'h00;
  localparam urd_byte_t READ_IDLE = 8'h00;

  // Prescaler ratios
  localparam int PRESCALE_SLOW = 4;
  localparam logic [1:0] PRESCALE_LAST = 2'(PRESCALE_SLOW - 1);
  localparam logic [1:0] PRESCALE_ZERO = 2'h0;

  typedef struct packed {
    urd_byte_t div_low;
    urd_byte_t div_high;
    urd_byte_t feature;
    urd_byte_t line_ctl;
    urd_byte_t modem_ctl;
    urd_byte_t int_enable;
    urd_byte_t fifo_ctl;
    urd_byte_t resume_one;
    urd_byte_t resume_two;
    urd_byte_t pause_one;
    urd_byte_t pause_two;
    urd_byte_t thresholds;
    urd_byte_t trig_levels;
    urd_byte_t scratch;
  } urd_cfg_s;

  // Live status supplied by the rest of the channel
  typedef struct packed {
    urd_byte_t rx_data;
    urd_byte_t int_ident;
    urd_byte_t line_stat;
    urd_byte_t modem_stat;
    urd_byte_t fifo_ready;
  } urd_stat_s;

endpackage

// ---- logic/urd_decode.sv ----
/*
  Register access decoder for one UART channel: bank selection from
  line control, enhanced enable and modem control, write gating, the
  shared FIFO readiness read and the input clock prescaler.
  Assumes host strobes and selects are synchronous to sys_clk and held
  low for at least two clocks per access.
*/
`timescale 1ns/1ps
module urd_decode #(
  parameter int CHAN = 0
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [urd_pkg::URD_CHANNELS-1:0] chan_select_n,
  input wire urd_pkg::urd_addr_t host_addr,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire urd_pkg::urd_byte_t host_d_in,
  output urd_pkg::urd_byte_t host_d_out,
  output logic host_d_oe,
  input wire urd_pkg::urd_stat_s chan_stat,
  output urd_pkg::urd_cfg_s chan_cfg,
  output logic tx_load,
  output urd_pkg::urd_byte_t tx_data,
  output logic rx_take,
  output logic prescale_tick
);
  import urd_pkg::*;

  urd_cfg_s cfg_q;
  logic wr_n_q;
  logic rd_n_q;
  logic own_sel;
  logic any_sel;
  logic wr_evt;
  logic rd_evt;
  logic enh_bank;
  logic div_bank;
  logic enh_on;
  logic ext_on;
  logic rdy_on;
  logic rdy_hit;
  urd_byte_t rd_d;
  urd_byte_t rd_q;
  urd_byte_t tx_q;
  logic tx_load_q;
  logic rx_take_q;
  logic [1:0] pre_cnt_q;
  logic pre_tick_q;

  assign own_sel = ~chan_select_n[CHAN];
  assign any_sel = ~&chan_select_n;
  assign wr_evt = own_sel && !host_wr_n && wr_n_q;
  assign rd_evt = !host_rd_n && rd_n_q;
  assign enh_bank = cfg_q.line_ctl == LINE_ENH_BANK;
  assign div_bank = cfg_q.line_ctl[LINE_DIV_BIT];
  assign enh_on = cfg_q.feature[FEAT_ENH_BIT];
  assign ext_on = enh_on && cfg_q.modem_ctl[MODEM_EXT_BIT];
  // Readiness is visible through any channel select
  assign rdy_on = any_sel && cfg_q.modem_ctl[MODEM_RDY_EN_BIT]
                  && !cfg_q.modem_ctl[MODEM_LOOP_BIT];
  // One term for mux and drive enable, so both agree on bank exclusions
  assign rdy_hit = rdy_on && host_addr == OFS_7 && !enh_bank
                   && !(own_sel && div_bank);

  // Strobe history for single-shot write and read side effects
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
    end else begin
      wr_n_q <= host_wr_n;
      rd_n_q <= host_rd_n;
    end
  end

  // Register writes, decoded by bank
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= '{default: REG_RESET};
    end else if (wr_evt) begin
      if (host_addr == OFS_3) begin
        cfg_q.line_ctl <= host_d_in;
      end else if (enh_bank) begin
        if (host_addr == OFS_0) begin
          cfg_q.div_low <= host_d_in;
        end else if (host_addr == OFS_1) begin
          cfg_q.div_high <= host_d_in;
        end else if (host_addr == OFS_2) begin
          cfg_q.feature <= host_d_in;
        end else if (host_addr == OFS_4) begin
          cfg_q.resume_one <= host_d_in;
        end else if (host_addr == OFS_5) begin
          cfg_q.resume_two <= host_d_in;
        end else if (host_addr == OFS_6) begin
          cfg_q.pause_one <= host_d_in;
        end else begin
          cfg_q.pause_two <= host_d_in;
        end
      end else if (div_bank && host_addr == OFS_0) begin
        cfg_q.div_low <= host_d_in;
      end else if (div_bank && host_addr == OFS_1) begin
        cfg_q.div_high <= host_d_in;
      end else if (host_addr == OFS_1) begin
        cfg_q.int_enable <= enh_on ? host_d_in
          : (cfg_q.int_enable & INT_EN_ENH_MASK) | (host_d_in & ~INT_EN_ENH_MASK);
      end else if (host_addr == OFS_2) begin
        cfg_q.fifo_ctl <= enh_on ? host_d_in
          : (cfg_q.fifo_ctl & FIFO_CTL_ENH_MASK) | (host_d_in & ~FIFO_CTL_ENH_MASK);
      end else if (host_addr == OFS_4) begin
        // Prescale select lives in the guarded top bits
        cfg_q.modem_ctl <= enh_on ? host_d_in
          : (cfg_q.modem_ctl & MODEM_ENH_MASK) | (host_d_in & ~MODEM_ENH_MASK);
      end else if (host_addr == OFS_6 && ext_on) begin
        // No check that halt exceeds resume; software owns that
        cfg_q.thresholds <= host_d_in;
      end else if (host_addr == OFS_7 && ext_on) begin
        cfg_q.trig_levels <= host_d_in;
      end else if (host_addr == OFS_7 && !rdy_hit) begin
        // Scratch only while readiness is hidden; a readiness write changes nothing unless ext_on sends it to trig_levels
        cfg_q.scratch <= host_d_in;
      end
    end
  end

  // Read mux, same bank order as writes
  always_comb begin
    rd_d = READ_IDLE;
    if (rdy_hit) begin
      rd_d = chan_stat.fifo_ready;
    end else if (!own_sel) begin
      rd_d = READ_IDLE;
    end else if (host_addr == OFS_3) begin
      rd_d = cfg_q.line_ctl;
    end else if (enh_bank) begin
      if (host_addr == OFS_0) begin
        rd_d = cfg_q.div_low;
      end else if (host_addr == OFS_1) begin
        rd_d = cfg_q.div_high;
      end else if (host_addr == OFS_2) begin
        rd_d = cfg_q.feature;
      end else if (host_addr == OFS_4) begin
        rd_d = cfg_q.resume_one;
      end else if (host_addr == OFS_5) begin
        rd_d = cfg_q.resume_two;
      end else if (host_addr == OFS_6) begin
        rd_d = cfg_q.pause_one;
      end else begin
        rd_d = cfg_q.pause_two;
      end
    end else if (div_bank && host_addr == OFS_0) begin
      rd_d = cfg_q.div_low;
    end else if (div_bank && host_addr == OFS_1) begin
      rd_d = cfg_q.div_high;
    end else if (host_addr == OFS_0) begin
      rd_d = chan_stat.rx_data;
    end else if (host_addr == OFS_1) begin
      rd_d = cfg_q.int_enable;
    end else if (host_addr == OFS_2) begin
      rd_d = chan_stat.int_ident;
    end else if (host_addr == OFS_4) begin
      rd_d = cfg_q.modem_ctl;
    end else if (host_addr == OFS_5) begin
      rd_d = chan_stat.line_stat;
    end else if (host_addr == OFS_6) begin
      rd_d = ext_on ? cfg_q.thresholds : chan_stat.modem_stat;
    end else begin
      rd_d = ext_on ? cfg_q.trig_levels : cfg_q.scratch;
    end
  end

  // Read data held in flops so the bus sees a stable byte
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q <= READ_IDLE;
    end else if (!host_rd_n) begin
      rd_q <= rd_d;
    end
  end

  assign host_d_out = rd_q;
  assign host_d_oe = !host_rd_n && !rd_n_q
                     && (own_sel || rdy_hit);

  // Data port side effects: one pulse per access
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_q <= REG_RESET;
      tx_load_q <= 1'b0;
      rx_take_q <= 1'b0;
    end else begin
      tx_load_q <= wr_evt && host_addr == OFS_0 && !div_bank && !enh_bank;
      rx_take_q <= rd_evt && own_sel && host_addr == OFS_0 && !div_bank && !enh_bank;
      if (wr_evt && host_addr == OFS_0 && !div_bank && !enh_bank) begin
        tx_q <= host_d_in;
      end
    end
  end

  // Input clock prescaler ahead of the baud generator
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_cnt_q <= PRESCALE_ZERO;
      pre_tick_q <= 1'b0;
    end else if (cfg_q.modem_ctl[MODEM_PRESCALE_BIT]) begin
      pre_tick_q <= pre_cnt_q == PRESCALE_LAST;
      pre_cnt_q <= (pre_cnt_q == PRESCALE_LAST) ? PRESCALE_ZERO : pre_cnt_q + 2'h1;
    end else begin
      pre_tick_q <= 1'b1;
      pre_cnt_q <= PRESCALE_ZERO;
    end
  end

  assign chan_cfg = cfg_q;
  assign tx_load = tx_load_q;
  assign tx_data = tx_q;
  assign rx_take = rx_take_q;
  assign prescale_tick = pre_tick_q;

endmodule

// ---- dv/urd_host.sv ----
/* Host processor model for the decoder bus.
   Assumes sys_clk from the bench; own_sel picks the selects. */
`timescale 1ns/1ps
module urd_host (
  input wire logic sys_clk,
  output logic [3:0] sel_n,
  output urd_pkg::urd_addr_t addr,
  output logic rd_n,
  output logic wr_n,
  output urd_pkg::urd_byte_t d_in,
  input wire urd_pkg::urd_byte_t d_out
);
  import urd_pkg::*;
  logic [3:0] own_sel = 4'hE;
  initial begin
    sel_n = 4'hF;
    addr = 3'h0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    d_in = 8'h00;
  end
  task automatic wr(input urd_addr_t a, input urd_byte_t d);
    @(posedge sys_clk);
    sel_n <= own_sel;
    addr <= a;
    d_in <= d;
    wr_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    wr_n <= 1'b1;
    sel_n <= 4'hF;
    d_in <= ~d;  // Released bus must not show the old byte
  endtask
  task automatic rd(input urd_addr_t a, output urd_byte_t d);
    @(posedge sys_clk);
    sel_n <= own_sel;
    addr <= a;
    rd_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    d = d_out;
    rd_n <= 1'b1;
    sel_n <= 4'hF;
  endtask
endmodule

// ---- dv/urd_decode_chk.sv ----
/* Port checker for the channel decoder.
   Assumes one clock domain and the bind below. */
`timescale 1ns/1ps
module urd_decode_chk #(
  parameter int CHAN = 0
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [urd_pkg::URD_CHANNELS-1:0] chan_select_n,
  input wire urd_pkg::urd_addr_t host_addr,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire urd_pkg::urd_byte_t host_d_in,
  input wire urd_pkg::urd_byte_t host_d_out,
  input wire logic host_d_oe,
  input wire urd_pkg::urd_stat_s chan_stat,
  input wire urd_pkg::urd_cfg_s chan_cfg,
  input wire logic prescale_tick,
  input wire logic tx_load,
  input wire urd_pkg::urd_byte_t tx_data,
  input wire logic rx_take
);
  import urd_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire take = !host_wr_n && !chan_select_n[CHAN];
  wire ext = chan_cfg.feature[FEAT_ENH_BIT] && chan_cfg.modem_ctl[MODEM_EXT_BIT];
  wire m7 = chan_cfg.modem_ctl[MODEM_PRESCALE_BIT];
  wire div = chan_cfg.line_ctl[LINE_DIV_BIT];
  AST_OE_OFF: assert property (host_rd_n || $past(host_rd_n) |-> !host_d_oe)
    else $error("drive outside a read");
  AST_OE_RDY: assert property (!host_rd_n && !$past(host_rd_n) && chan_select_n[CHAN]
    && !(&chan_select_n) && host_addr == OFS_7 && chan_cfg.modem_ctl[2]
    && !chan_cfg.modem_ctl[4] && chan_cfg.line_ctl == 8'h00 |-> host_d_oe)
    else $error("readiness not driven");
  AST_TX_LOAD: assert property (take && $past(host_wr_n) && host_addr == OFS_0 && !div
    |=> tx_load && tx_data == $past(host_d_in)) else $error("data port write lost");
  AST_DIV_NO_TX: assert property (take && $past(host_wr_n) && host_addr == OFS_0 && div
    |=> !tx_load) else $error("divisor write sent");
  AST_RX_TAKE: assert property (!host_rd_n && $past(host_rd_n) && !chan_select_n[CHAN]
    && host_addr == OFS_0 |=> rx_take != $past(div)) else $error("data port read");
  AST_LINE_WR: assert property (take && $past(host_wr_n) && host_addr == OFS_3
    |=> chan_cfg.line_ctl == $past(host_d_in)) else $error("line control lost");
  AST_DIV_ONE: assert property (!$past(m7) && $past(arst_n, 2) |-> prescale_tick)
    else $error("tick missing");
  AST_DIV_FOUR: assert property (m7 && $past(m7) && $past(m7, 2)
    |-> !(prescale_tick && $past(prescale_tick))) else $error("tick too often");
  AST_GUARD: assert property (take && $past(host_wr_n) && host_addr == OFS_4
    && chan_cfg.line_ctl == 8'h00 && !chan_cfg.feature[FEAT_ENH_BIT]
    |=> chan_cfg.modem_ctl[7:5] == $past(chan_cfg.modem_ctl[7:5])) else $error("guard");
  AST_TCR: assert property (take && $past(host_wr_n) && !ext
    |=> $stable(chan_cfg.thresholds)) else $error("threshold written");
  AST_RDY: assert property (!host_rd_n && host_addr == OFS_7 && !(&chan_select_n)
    && chan_cfg.modem_ctl[2] && !chan_cfg.modem_ctl[4] && chan_cfg.line_ctl == 8'h00
    |=> host_d_out == $past(chan_stat.fifo_ready)) else $error("readiness");
  AST_UNSEL: assert property (!host_rd_n && &chan_select_n
    |=> host_d_out == READ_IDLE) else $error("unselected read");
endmodule
bind urd_decode urd_decode_chk #(.CHAN(CHAN)) u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .chan_select_n(chan_select_n), .host_addr(host_addr), .host_rd_n(host_rd_n),
  .host_wr_n(host_wr_n), .host_d_in(host_d_in), .host_d_out(host_d_out),
  .host_d_oe(host_d_oe), .chan_stat(chan_stat), .chan_cfg(chan_cfg),
  .prescale_tick(prescale_tick), .tx_load(tx_load), .tx_data(tx_data), .rx_take(rx_take));

// ---- dv/urd_decode_test.sv ----
/* Self-checking bench for the channel decoder.
   Assumes the host model drives the bus; status inputs are fixed. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", n, e, s); end end
module urd_decode_test;
  import urd_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] sel_n;
  logic rd_n, wr_n, oe, tick;
  urd_addr_t addr;
  urd_byte_t d_in, d_out, v, sv, n, txd;
  urd_stat_s stat = '{8'h11, 8'h22, 8'h33, 8'h44, 8'hA5};
  urd_cfg_s cfg;
  int failures = 0;
  int tests_run = 0;
  always #12.5 sys_clk = ~sys_clk;
  urd_host host (.sys_clk(sys_clk), .sel_n(sel_n), .addr(addr), .rd_n(rd_n),
    .wr_n(wr_n), .d_in(d_in), .d_out(d_out));
  urd_decode #(.CHAN(0)) dut (.sys_clk(sys_clk), .arst_n(arst_n), .chan_select_n(sel_n),
    .host_addr(addr), .host_rd_n(rd_n), .host_wr_n(wr_n), .host_d_in(d_in),
    .host_d_out(d_out), .host_d_oe(oe), .chan_stat(stat), .chan_cfg(cfg),
    .tx_load(), .tx_data(txd), .rx_take(), .prescale_tick(tick));
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic t_banks();
    urd_addr_t ofs [5] = '{OFS_6, OFS_4, OFS_7, OFS_5, OFS_2};
    host.rd(OFS_3, sv);
    host.wr(OFS_3, 8'h80);
    host.wr(OFS_0, 8'h34);
    host.wr(OFS_1, 8'h12);
    `CHK("divisor", 16'h1234, {cfg.div_high, cfg.div_low})
    host.rd(OFS_0, v);
    `CHK("divisor low", 8'h34, v)
    `CHK("data port idle", 8'h00, txd)
    host.wr(OFS_3, LINE_ENH_BANK);
    foreach (ofs[i]) host.wr(ofs[i], 8'h61 + 8'(i));
    foreach (ofs[i]) begin
      host.rd(ofs[i], v);
      `CHK("bank byte", 8'h61 + 8'(i), v)
    end
    `CHK("pause two", 8'h63, cfg.pause_two)
    host.wr(OFS_3, sv);
    $display("bank test done");
  endtask
  task automatic t_gates();
    host.wr(OFS_0, 8'hC3);
    `CHK("data port", 8'hC3, txd)
    host.rd(OFS_0, v);
    `CHK("rx data", 8'h11, v)
    host.wr(OFS_4, 8'hFF);
    host.rd(OFS_4, v);
    `CHK("guarded modem", 8'h1F, v)
    host.wr(OFS_4, 8'h00);
    host.wr(OFS_6, 8'h5A);
    `CHK("locked thresholds", 8'h00, cfg.thresholds)
    host.wr(OFS_3, LINE_ENH_BANK);
    host.rd(OFS_2, v);
    host.wr(OFS_2, v + 8'h10);
    host.wr(OFS_3, 8'h00);
    host.rd(OFS_4, sv);
    host.wr(OFS_4, sv + 8'h40);
    host.wr(OFS_6, 8'h3A);
    host.wr(OFS_7, 8'h48);
    host.rd(OFS_6, v);
    `CHK("thresholds", 8'h3A, v)
    host.rd(OFS_7, v);
    `CHK("trigger levels", 8'h48, v)
    host.wr(OFS_4, sv);
    $display("gate test done");
  endtask
  task automatic t_ready();
    host.rd(OFS_4, sv);
    host.wr(OFS_4, sv | 8'h04);
    host.wr(OFS_7, 8'h5D);
    `CHK("readiness write", 8'h00, cfg.scratch)
    `CHK("trigger kept", 8'h48, cfg.trig_levels)
    host.wr(OFS_4, (sv & 8'hEF) + 8'h44);
    host.wr(OFS_7, 8'h00);
    host.rd(OFS_7, v);
    `CHK("readiness", 8'hA5, v)
    host.own_sel = 4'hB;
    host.rd(OFS_7, v);
    `CHK("readiness other", 8'hA5, v)
    host.own_sel = 4'hF;
    host.rd(OFS_7, v);
    `CHK("unselected", READ_IDLE, v)
    host.own_sel = 4'hE;
    host.wr(OFS_4, sv);
    $display("readiness test done");
  endtask
  task automatic t_prescale(input urd_byte_t m, input urd_byte_t exp);
    host.wr(OFS_4, m);
    n = 8'h00;
    repeat (16) begin
      // Sample away from the edge that launches the tick
      @(negedge sys_clk);
      n = n + 8'(tick);
    end
    `CHK("ticks", exp, n)
    $display("prescale test done");
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    `CHK("cfg reset", 112'h0, cfg)
    t_banks();
    t_gates();
    t_ready();
    t_prescale(8'h80, 8'h04);
    t_prescale(8'h00, 8'h10);
    results();
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    failures++;
    results();
  end
endmodule
